// *** rtl/shp_pkg.sv ***
package shp_pkg;

  // System clock rate
  localparam int CLK_HZ = 125_000_000;
  // Fastest serial clock the 2-wire side must follow
  localparam int SCL_MAX_HZ = 1_000_000;
  // System cycles in the shortest serial clock half period
  localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
  // Synchroniser plus edge detect latency in system cycles
  localparam int PIN_LAT_CYC = 3;

  // Carrier periods per elementary time unit
  localparam logic [8:0] ETU_CARRIERS = 9'd372;
  // Character: start, 8 data, parity, 2 guard units
  localparam logic [3:0] CHAR_BITS = 4'd12;
  // Answer-to-reset length in bytes
  localparam logic [3:0] ATR_BYTES = 4'h8;
  // Carrier rises seen during reset that mean a running clock
  localparam logic [2:0] CLK_RUN_EDGES = 3'h4;

  // Command opcodes, low nibble of the first byte
  localparam logic [3:0] OPC_WR_USER = 4'h0;
  localparam logic [3:0] OPC_RAND_RD = 4'h1;
  localparam logic [3:0] OPC_RD_USER = 4'h2;
  localparam logic [3:0] OPC_SYS_WR = 4'h4;
  localparam logic [3:0] OPC_SYS_RD = 4'h6;
  localparam logic [3:0] OPC_VERIFY_PW = 4'ha;

  // System write first parameter values
  localparam logic [7:0] SYSWR_CFG = 8'h00;
  localparam logic [7:0] SYSWR_FUSE = 8'h01;

  // Password set that unlocks the configuration zone
  localparam logic [2:0] CFG_UNLOCK_PW_IDX = 3'h7;
  // Bit of the password parameter that selects the read password
  localparam int PW_READ_BIT = 4;

  // Memory extents and zone layout
  localparam logic [15:0] USER_LAST_ADDR = 16'h03ff;
  localparam logic [15:0] CFG_LAST_ADDR = 16'h00ff;
  localparam int ZONE_LSB = 7;

  // Byte index in a frame where data starts
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] IDX_MAX = 3'h7;
  localparam logic [2:0] IDX_PW_LAST = 3'h6;

  typedef enum logic [2:0] {
    SHP_IDLE = 3'b000,
    SHP_RX = 3'b001,
    SHP_ACK = 3'b010,
    SHP_TX = 3'b011,
    SHP_TXACK = 3'b100
  } shp_state_t;

endpackage

// *** rtl/shp_link_if.sv ***
`timescale 1ns/1ps
interface shp_link_if;
  logic scl;
  logic sda;
  logic rst_n;
  logic scl_rise;
  logic scl_fall;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_clr;
  logic tx_busy;
  logic tx_line;

  modport sync (output scl, output sda, output rst_n, output scl_rise, output scl_fall);
  modport tx (input scl_rise, input tx_start, input tx_data, input tx_clr, output tx_busy, output tx_line);
  modport core (input scl, input sda, input rst_n, input scl_rise, input scl_fall, input tx_busy,
                input tx_line, output tx_start, output tx_data, output tx_clr);
endinterface

// *** rtl/shp_pin_sync.sv ***
`timescale 1ns/1ps
module shp_pin_sync
  import shp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic rst_n_i,
  shp_link_if.sync lnk
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic scl_prev;
  } shp_sync_t;

  shp_sync_t r, n;

  // Idle levels: lines pulled up, reset pin weakly pulled high
  localparam shp_sync_t SYNC_RST = '{s1: 3'h7, s2: 3'h7, scl_prev: 1'b1};

  // Three cycle latency, far below a 1 MHz half period
  always_comb begin
    n = r;
    n.s1 = {rst_n_i, sda_i, scl_i};
    n.s2 = r.s1;
    n.scl_prev = r.s2[0];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= SYNC_RST;
    end else begin
      r <= n;
    end
  end

  assign lnk.scl = r.s2[0];
  assign lnk.sda = r.s2[1];
  assign lnk.rst_n = r.s2[2];
  assign lnk.scl_rise = r.s2[0] & ~r.scl_prev;
  assign lnk.scl_fall = ~r.s2[0] & r.scl_prev;

endmodule // shp_pin_sync

// *** rtl/shp_etu_tx.sv ***
`timescale 1ns/1ps
module shp_etu_tx
  import shp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  shp_link_if.tx lnk
);

  typedef struct packed {
    logic busy;
    logic [3:0] bitn;
    logic [8:0] cnt;
    logic [11:0] sh;
  } shp_tx_t;

  shp_tx_t r, n;

  localparam shp_tx_t TX_RST = '{busy: 1'b0, bitn: 4'h0, cnt: 9'h000, sh: 12'hfff};

  always_comb begin
    n = r;
    if (lnk.tx_clr) begin
      n = TX_RST;
    end else if (lnk.tx_start && !r.busy) begin
      // Guard, guard, even parity, data LSB first, start
      n.busy = 1'b1;
      n.bitn = 4'h0;
      n.cnt = 9'h000;
      n.sh = {2'b11, ^lnk.tx_data, lnk.tx_data, 1'b0};
    end else if (r.busy && lnk.scl_rise) begin
      if (r.cnt == ETU_CARRIERS - 9'd1) begin
        n.cnt = 9'h000;
        n.sh = {1'b1, r.sh[11:1]};
        n.bitn = r.bitn + 4'h1;
        if (r.bitn == CHAR_BITS - 4'h1) begin
          n.busy = 1'b0;
        end
      end else begin
        n.cnt = r.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= TX_RST;
    end else begin
      r <= n;
    end
  end

  assign lnk.tx_busy = r.busy;
  assign lnk.tx_line = r.busy ? r.sh[0] : 1'b1;

endmodule // shp_etu_tx

// *** rtl/shp_top.sv ***
// Function
// - Async bit lasts 372 carrier periods
// - Sync mode samples data on rising clock
// - Sync mode changes data on falling clock
// - Data pin is open drain only
// - Async reset sends 64-bit answer-to-reset
// - Reset pin low clears logic, rights, writes
// - Async activation flag survives reset pin
// - Reset pin idles high, weak pull-up
// - No answer-to-reset in sync mode
// - Device address selects one of 16
// - Sync interface works to 1 MHz
// - Random read streams bytes to memory end
// - Config access needs password seven verified
// - Blown fuses lock configuration writes
// - User access checked by control logic on each written byte and at the start of each read
`timescale 1ns/1ps
module shp_top
  import shp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_CLK_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic RST_PIN_N_I,
  output logic RST_PULLUP_EN_O,
  input wire logic [3:0] DEV_ADDR_I,
  input wire logic [63:0] ATR_I,
  input wire logic [23:0] PW7_I,
  input wire logic FUSES_BLOWN_I,
  input wire logic [7:0] ZONE_WR_OK_I,
  input wire logic [7:0] ZONE_RD_OK_I,
  input wire logic [7:0] MEM_RDATA_I,
  output logic [15:0] MEM_ADDR_O,
  output logic MEM_CFG_O,
  output logic [7:0] MEM_WDATA_O,
  output logic MEM_WE_O,
  output logic FUSE_BLOW_O,
  output logic CFG_UNLOCKED_O,
  output logic ASYNC_MODE_O,
  output logic ATR_BUSY_O
);

  typedef struct packed {
    shp_state_t st;
    logic [3:0] opc;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [2:0] idx;
    logic drive;
    logic [15:0] addr;
    logic at_end;
    logic cfg_sel;
    logic [7:0] p1;
    logic [7:0] wdata;
    logic we;
    logic fuse_blow;
    logic unlocked;
    logic [23:0] pw;
    logic more;
    logic sda_prev;
    logic rst_prev;
    logic [2:0] run_cnt;
    logic async_mode;
    logic atr_act;
    logic [3:0] atr_idx;
    logic tx_start;
    logic [7:0] tx_data;
  } shp_core_t;

  localparam shp_core_t CORE_RST = '{
    st: SHP_IDLE, opc: 4'h0, bitc: 4'h0, sh: 8'h00, idx: 3'h0, drive: 1'b0, addr: 16'h0000,
    at_end: 1'b0, cfg_sel: 1'b0, p1: 8'h00, wdata: 8'h00, we: 1'b0, fuse_blow: 1'b0,
    unlocked: 1'b0, pw: 24'h000000, more: 1'b0, sda_prev: 1'b1, rst_prev: 1'b1, run_cnt: 3'h0,
    async_mode: 1'b0, atr_act: 1'b0, atr_idx: 4'h0, tx_start: 1'b0, tx_data: 8'h00};

  shp_link_if lnk ();
  shp_core_t r, n;

  shp_pin_sync shp_pin_sync_inst (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .scl_i(SCL_CLK_I),
    .sda_i(SDA_I),
    .rst_n_i(RST_PIN_N_I),
    .lnk(lnk.sync)
  );

  shp_etu_tx shp_etu_tx_inst (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .lnk(lnk.tx)
  );

  function automatic logic [15:0] last_addr(input logic cfg);
    last_addr = cfg ? CFG_LAST_ADDR : USER_LAST_ADDR;
  endfunction

  function automatic logic [2:0] zone_of(input logic [15:0] a);
    zone_of = a[ZONE_LSB +: 3];
  endfunction

  function automatic logic [7:0] atr_byte(input logic [63:0] atr, input logic [2:0] i);
    logic [63:0] w;
    w = atr << {i, 3'b000};
    atr_byte = w[63:56];
  endfunction

  function automatic logic opc_valid(input logic [3:0] o);
    opc_valid = (o == OPC_WR_USER) || (o == OPC_RAND_RD) || (o == OPC_RD_USER) || (o == OPC_SYS_WR)
      || (o == OPC_SYS_RD) || (o == OPC_VERIFY_PW);
  endfunction

  logic start_cond;
  logic stop_cond;
  logic ack;

  always_comb begin
    n = r;
    ack = 1'b1;
    n.we = 1'b0;
    n.fuse_blow = 1'b0;
    n.tx_start = 1'b0;
    n.sda_prev = lnk.sda;
    n.rst_prev = lnk.rst_n;
    start_cond = lnk.scl && r.sda_prev && !lnk.sda && !r.drive;
    stop_cond = lnk.scl && !r.sda_prev && lnk.sda && !r.drive;
    // Step the address once the write strobe has been seen
    if (r.we && r.addr != last_addr(r.cfg_sel)) begin
      n.addr = r.addr + 16'h0001;
    end
    if (!lnk.rst_n) begin
      // All but the async flag and carrier edge count cleared, writes inhibited, rights dropped
      n = CORE_RST;
      n.async_mode = r.async_mode;
      n.rst_prev = 1'b0;
      n.sda_prev = lnk.sda;
      n.run_cnt = r.run_cnt;
      if (lnk.scl_rise && r.run_cnt != CLK_RUN_EDGES) begin
        n.run_cnt = r.run_cnt + 3'h1;
      end
    end else if (!r.rst_prev) begin
      // Release of the reset pin
      n.run_cnt = 3'h0;
      if (r.run_cnt == CLK_RUN_EDGES) begin
        n.async_mode = 1'b1;
        n.atr_act = 1'b1;
        n.atr_idx = 4'h0;
      end
    end else if (r.async_mode) begin
      // Answer-to-reset only exists on this path
      if (r.atr_act && !lnk.tx_busy && !r.tx_start) begin
        if (r.atr_idx == ATR_BYTES) begin
          n.atr_act = 1'b0;
        end else begin
          n.tx_start = 1'b1;
          n.tx_data = atr_byte(ATR_I, r.atr_idx[2:0]);
          n.atr_idx = r.atr_idx + 4'h1;
        end
      end
    end else if (start_cond) begin
      n.st = SHP_RX;
      n.bitc = 4'h0;
      n.idx = 3'h0;
    end else if (stop_cond) begin
      n.st = SHP_IDLE;
      n.drive = 1'b0;
    end else begin
      unique case (r.st)
        SHP_IDLE: begin
          n.drive = 1'b0;
        end
        SHP_RX: begin
          if (lnk.scl_rise && r.bitc != 4'h8) begin
            n.sh = {r.sh[6:0], lnk.sda};
            n.bitc = r.bitc + 4'h1;
          end else if (lnk.scl_fall && r.bitc == 4'h8) begin
            n.bitc = 4'h0;
            n.more = 1'b0;
            n.idx = (r.idx == IDX_MAX) ? IDX_MAX : r.idx + 3'h1;
            unique case (r.idx)
              3'h0: begin
                n.opc = r.sh[3:0];
                n.cfg_sel = (r.sh[3:0] == OPC_SYS_WR) || (r.sh[3:0] == OPC_SYS_RD);
                ack = (r.sh[7:4] == DEV_ADDR_I) && opc_valid(r.sh[3:0]);
              end
              3'h1: begin
                n.p1 = r.sh;
              end
              3'h2: begin
                n.addr = r.cfg_sel ? {8'h00, r.sh} : {r.p1, r.sh};
                n.at_end = 1'b0;
                if (r.opc == OPC_RAND_RD) begin
                  ack = ZONE_RD_OK_I[zone_of({r.p1, r.sh})];
                  n.more = ack;
                end
              end
              3'h3: begin
                if (r.opc == OPC_RD_USER) begin
                  ack = ZONE_RD_OK_I[zone_of(r.addr)];
                  n.more = ack;
                end else if (r.opc == OPC_SYS_RD) begin
                  ack = r.unlocked;
                  n.more = ack;
                end else if (r.opc == OPC_SYS_WR) begin
                  ack = r.unlocked && !FUSES_BLOWN_I;
                  if (r.p1 == SYSWR_FUSE) begin
                    n.fuse_blow = ack;
                  end else if (r.p1 != SYSWR_CFG) begin
                    ack = 1'b0;
                  end
                end
              end
              default: begin
                if (r.opc == OPC_WR_USER) begin
                  ack = ZONE_WR_OK_I[zone_of(r.addr)];
                  n.we = ack;
                  n.wdata = r.sh;
                end else if (r.opc == OPC_SYS_WR && r.p1 == SYSWR_CFG) begin
                  ack = r.unlocked && !FUSES_BLOWN_I;
                  n.we = ack;
                  n.wdata = r.sh;
                end else if (r.opc == OPC_VERIFY_PW) begin
                  n.pw = {r.pw[15:0], r.sh};
                  if (r.idx == IDX_PW_LAST && r.p1[2:0] == CFG_UNLOCK_PW_IDX && !r.p1[PW_READ_BIT]) begin
                    n.unlocked = ({r.pw[15:0], r.sh} == PW7_I);
                  end
                end else begin
                  ack = 1'b0;
                end
              end
            endcase
            n.st = ack ? SHP_ACK : SHP_IDLE;
            n.drive = ack;
          end
        end
        SHP_ACK: begin
          if (lnk.scl_fall) begin
            n.drive = 1'b0;
            if (r.more) begin
              n.sh = {MEM_RDATA_I[6:0], 1'b0};
              n.drive = ~MEM_RDATA_I[7];
              n.bitc = 4'h1;
              n.st = SHP_TX;
              n.at_end = (r.addr == last_addr(r.cfg_sel));
              if (r.addr != last_addr(r.cfg_sel)) begin
                n.addr = r.addr + 16'h0001;
              end
            end else begin
              n.st = SHP_RX;
            end
          end
        end
        SHP_TX: begin
          if (lnk.scl_fall) begin
            if (r.bitc == 4'h8) begin
              n.drive = 1'b0;
              n.more = 1'b0;
              n.st = SHP_TXACK;
            end else begin
              n.drive = ~r.sh[7];
              n.sh = {r.sh[6:0], 1'b0};
              n.bitc = r.bitc + 4'h1;
            end
          end
        end
        SHP_TXACK: begin
          if (lnk.scl_rise) begin
            n.more = !lnk.sda && !r.at_end;
          end else if (lnk.scl_fall) begin
            if (r.more) begin
              n.sh = {MEM_RDATA_I[6:0], 1'b0};
              n.drive = ~MEM_RDATA_I[7];
              n.bitc = 4'h1;
              n.st = SHP_TX;
              n.at_end = (r.addr == last_addr(r.cfg_sel));
              if (r.addr != last_addr(r.cfg_sel)) begin
                n.addr = r.addr + 16'h0001;
              end
            end else begin
              n.st = SHP_IDLE;
            end
          end
        end
        default: begin
          n.st = SHP_IDLE;
          n.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign lnk.tx_start = r.tx_start;
  assign lnk.tx_data = r.tx_data;
  assign lnk.tx_clr = ~lnk.rst_n;

  // Only ever pulls low or releases
  assign SDA_O = 1'b0;
  assign SDA_OE_O = r.async_mode ? ~lnk.tx_line : r.drive;
  assign RST_PULLUP_EN_O = 1'b1;
  assign MEM_ADDR_O = r.addr;
  assign MEM_CFG_O = r.cfg_sel;
  assign MEM_WDATA_O = r.wdata;
  assign MEM_WE_O = r.we;
  assign FUSE_BLOW_O = r.fuse_blow;
  assign CFG_UNLOCKED_O = r.unlocked;
  assign ASYNC_MODE_O = r.async_mode;
  assign ATR_BUSY_O = r.atr_act;

endmodule // shp_top

// *** tb/shp_top_assertions.sv ***
`timescale 1ns/1ps
module shp_top_assertions (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_CLK_I,
  input wire logic RST_PIN_N_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic RST_PULLUP_EN_O,
  input wire logic FUSES_BLOWN_I,
  input wire logic [7:0] ZONE_WR_OK_I,
  input wire logic [15:0] MEM_ADDR_O,
  input wire logic MEM_CFG_O,
  input wire logic MEM_WE_O,
  input wire logic FUSE_BLOW_O,
  input wire logic CFG_UNLOCKED_O,
  input wire logic ASYNC_MODE_O,
  input wire logic ATR_BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence pin_held_low;
    !RST_PIN_N_I [*5];
  endsequence
  sequence atr_go;
    $rose(ATR_BUSY_O);
  endsequence
  sequence cfg_write;
    MEM_WE_O && MEM_CFG_O;
  endsequence
  drain_only_a: assert property (SDA_O == 1'b0) else $error("data pin driven high");
  pullup_on_a: assert property (RST_PULLUP_EN_O == 1'b1) else $error("reset pull-up off");
  no_sync_atr_a: assert property (!ASYNC_MODE_O |-> !ATR_BUSY_O) else $error("atr in sync mode");
  flag_kept_a: assert property (ASYNC_MODE_O |=> ASYNC_MODE_O) else $error("async flag lost");
  pin_clear_a: assert property (pin_held_low |-> !CFG_UNLOCKED_O && !MEM_WE_O && !ATR_BUSY_O)
    else $error("state kept under reset pin");
  fall_change_a: assert property (!ASYNC_MODE_O && $changed(SDA_OE_O) |-> !SCL_CLK_I && !$past(SCL_CLK_I, 2))
    else $error("data changed off falling clock");
  atr_start_a: assert property (atr_go |-> ##[0:12] SDA_OE_O) else $error("no start bit");
  cfg_gate_a: assert property (cfg_write |-> CFG_UNLOCKED_O) else $error("config write while locked");
  fuse_lock_a: assert property (FUSES_BLOWN_I |-> !FUSE_BLOW_O && !(MEM_WE_O && MEM_CFG_O))
    else $error("config change after fuses");
  zone_gate_a: assert property (MEM_WE_O && !MEM_CFG_O |-> ZONE_WR_OK_I[MEM_ADDR_O[9:7]])
    else $error("zone write not permitted");
  write_step_a: assert property (MEM_WE_O |=> !MEM_WE_O && MEM_ADDR_O == $past(MEM_ADDR_O) + 16'h1)
    else $error("write address not stepped");
  async_sel_a: assert property ($rose(ASYNC_MODE_O) |-> RST_PIN_N_I && !$past(RST_PIN_N_I, 4))
    else $error("async without reset pin release");
  atr_seen_c: cover property (atr_go);
endmodule // shp_top_assertions
bind shp_top shp_top_assertions shp_top_assertions_inst (.CLK_I(CLK_I), .RST_I(RST_I),
  .SCL_CLK_I(SCL_CLK_I), .RST_PIN_N_I(RST_PIN_N_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .RST_PULLUP_EN_O(RST_PULLUP_EN_O), .FUSES_BLOWN_I(FUSES_BLOWN_I), .ZONE_WR_OK_I(ZONE_WR_OK_I),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_CFG_O(MEM_CFG_O), .MEM_WE_O(MEM_WE_O), .FUSE_BLOW_O(FUSE_BLOW_O),
  .CFG_UNLOCKED_O(CFG_UNLOCKED_O), .ASYNC_MODE_O(ASYNC_MODE_O), .ATR_BUSY_O(ATR_BUSY_O));

// *** tb/shp_host_model.sv ***
`timescale 1ns/1ps
module shp_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o,
  output logic rst_pin_n_o
);
  // Half serial clock in system cycles, under 1 MHz
  localparam int HALF = 64;
  // Carrier 80 ns, so one unit is 372 * 10 cycles
  localparam int ETU = 3720;
  logic scl_r = 1'b1;
  logic car_r = 1'b0;
  logic car_en_r = 1'b0;
  int car_cnt = 0;
  initial begin
    sda_pull_o = 1'b0;
    rst_pin_n_o = 1'b1;
  end
  always @(posedge clk_i) begin
    if (car_en_r) begin
      car_cnt <= (car_cnt == 4) ? 0 : car_cnt + 1;
      if (car_cnt == 4) car_r <= !car_r;
    end
  end
  assign scl_o = car_en_r ? car_r : scl_r;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data set while clock low, device reads at rise
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o <= !b;
    cyc(HALF / 2);
    scl_r <= 1'b1;
    cyc(HALF / 2);
    r = sda_i;
    cyc(HALF / 2);
    scl_r <= 1'b0;
    cyc(HALF / 2);
  endtask
  task automatic xfer(input logic [63:0] bytes, input int n, input int nrd, output int acks, output logic [23:0] rd);
    logic r;
    logic [7:0] b;
    acks = 0;
    rd = 24'h0;
    sda_pull_o <= 1'b0;
    scl_r <= 1'b1;
    cyc(HALF);
    sda_pull_o <= 1'b1;
    cyc(HALF);
    scl_r <= 1'b0;
    cyc(HALF / 2);
    for (int i = 0; i < n && acks == i; i++) begin
      b = bytes[8*(n-1-i) +: 8];
      for (int k = 7; k >= 0; k--) bit_io(b[k], r);
      bit_io(1'b1, r);
      if (!r) acks++;
    end
    for (int j = 0; j < nrd; j++) begin
      for (int k = 0; k < 8; k++) begin
        bit_io(1'b1, r);
        b = {b[6:0], r};
      end
      bit_io(j == nrd - 1, r);
      rd = {rd[15:0], b};
    end
    sda_pull_o <= 1'b1;
    cyc(HALF / 2);
    scl_r <= 1'b1;
    cyc(HALF);
    sda_pull_o <= 1'b0;
    cyc(HALF);
  endtask
  task automatic pin_pulse();
    rst_pin_n_o <= 1'b0;
    cyc(20);
    rst_pin_n_o <= 1'b1;
    cyc(10);
  endtask
  // Reset with running carrier, then read first character
  task automatic async_atr(output logic [7:0] d, output int ok);
    ok = 0;
    d = 8'h0;
    rst_pin_n_o <= 1'b0;
    car_en_r <= 1'b1;
    cyc(100);
    rst_pin_n_o <= 1'b1;
    for (int t = 0; t < 300 && ok == 0; t++) begin
      cyc(1);
      if (!sda_i) ok = 1;
    end
    cyc(ETU / 2 + ETU);
    for (int k = 0; k < 8; k++) begin
      d[k] = sda_i;
      cyc(ETU);
    end
  endtask
endmodule // shp_host_model

// *** tb/shp_top_tb.sv ***
`timescale 1ns/1ps
module shp_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fuses_blown = 1'b0;
  logic [7:0] zone_wr_ok = 8'hff;
  logic scl, host_pull, pin_n, sda, sda_oe, pullup_en, mem_cfg, mem_we, fuse_blow, unlocked, async_mode, atr_busy;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [15:0] we_addr;
  logic [7:0] we_data;
  logic we_cfg;
  int we_cnt = 0;
  int fuse_cnt = 0;
  int miscompares = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  // Wire with pull-up, low if anyone pulls
  assign sda = !(sda_oe | host_pull);
  shp_host_model shp_host_model_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(host_pull),
    .rst_pin_n_o(pin_n));
  shp_top shp_top_inst (.CLK_I(clk), .RST_I(rst), .SCL_CLK_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe),
    .RST_PIN_N_I(pin_n), .RST_PULLUP_EN_O(pullup_en), .DEV_ADDR_I(4'h3), .ATR_I(64'h96a5_0f11_2233_4455),
    .PW7_I(24'h123456), .FUSES_BLOWN_I(fuses_blown), .ZONE_WR_OK_I(zone_wr_ok), .ZONE_RD_OK_I(8'hff),
    .MEM_RDATA_I(mem_addr[7:0] ^ 8'h3c), .MEM_ADDR_O(mem_addr), .MEM_CFG_O(mem_cfg), .MEM_WDATA_O(mem_wdata),
    .MEM_WE_O(mem_we), .FUSE_BLOW_O(fuse_blow), .CFG_UNLOCKED_O(unlocked), .ASYNC_MODE_O(async_mode),
    .ATR_BUSY_O(atr_busy));
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      we_addr <= mem_addr;
      we_data <= mem_wdata;
      we_cfg <= mem_cfg;
      we_cnt <= we_cnt + 1;
    end
    if (fuse_blow === 1'b1) fuse_cnt <= fuse_cnt + 1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    miscompares++;
    $display("[FAIL] %0t watchdog", $time);
    conclude();
  end
  initial begin
    int a;
    logic [23:0] rd;
    logic [7:0] d;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk(24'(sda_oe), 24'h0, "idle release");
    chk(24'(pullup_en), 24'h1, "pull-up");
    chk(24'(async_mode), 24'h0, "sync default");
    shp_host_model_inst.xfer(64'h30000501a5, 5, 0, a, rd);
    chk(24'(a), 24'd5, "write acks");
    chk({we_addr, we_data}, 24'h0005a5, "write data");
    chk({23'h0, we_cfg}, 24'h0, "user space");
    shp_host_model_inst.xfer(64'h40000501a5, 5, 0, a, rd);
    chk(24'(a), 24'd0, "other address");
    zone_wr_ok <= 8'hfe;
    shp_host_model_inst.xfer(64'h30000501a5, 5, 0, a, rd);
    chk(24'(we_cnt), 24'd1, "zone refused");
    zone_wr_ok <= 8'hff;
    $display("test user write done");
    shp_host_model_inst.xfer(64'h3103fe, 3, 3, a, rd);
    chk(rd, 24'hc2c3ff, "read to end");
    shp_host_model_inst.xfer(64'h32001001, 4, 1, a, rd);
    chk(rd, 24'h00002c, "user read");
    $display("test random read done");
    shp_host_model_inst.xfer(64'h3400400177, 5, 0, a, rd);
    chk(24'(we_cnt), 24'd1, "locked config");
    shp_host_model_inst.xfer(64'h3a070003123457, 7, 0, a, rd);
    chk(24'(unlocked), 24'h0, "bad password");
    shp_host_model_inst.xfer(64'h3a070003123456, 7, 0, a, rd);
    chk(24'(unlocked), 24'h1, "good password");
    shp_host_model_inst.xfer(64'h36004001, 4, 1, a, rd);
    chk(rd, 24'h00007c, "config read");
    shp_host_model_inst.xfer(64'h3400400177, 5, 0, a, rd);
    chk({we_addr, we_data}, 24'h004077, "config write");
    chk({23'h0, we_cfg}, 24'h1, "config space");
    shp_host_model_inst.xfer(64'h34010000, 4, 0, a, rd);
    chk(24'(fuse_cnt), 24'd1, "fuse blow");
    fuses_blown <= 1'b1;
    shp_host_model_inst.xfer(64'h3400400177, 5, 0, a, rd);
    chk(24'(we_cnt), 24'd2, "config locked");
    shp_host_model_inst.xfer(64'h34010000, 4, 0, a, rd);
    chk(24'(fuse_cnt), 24'd1, "fuse refused");
    $display("test config done");
    shp_host_model_inst.pin_pulse();
    chk(24'(unlocked), 24'h0, "rights cleared");
    chk({22'h0, async_mode, atr_busy}, 24'h0, "still sync");
    shp_host_model_inst.async_atr(d, a);
    chk(24'(a), 24'd1, "start bit");
    chk(24'(d), 24'h96, "first character");
    chk(24'(async_mode), 24'h1, "async set");
    shp_host_model_inst.pin_pulse();
    chk({22'h0, async_mode, atr_busy}, 24'h2, "flag kept");
    $display("test async done");
    conclude();
  end
endmodule // shp_top_tb
